//--- inc/crfb_defs.svh
// Widths, register counts and reset values of the banked CPU register file
`ifndef CRFB_DEFS_SVH
`define CRFB_DEFS_SVH
`define CRFB_WORD_W      16
`define CRFB_LONG_W      20
`define CRFB_BANK_REGS   7
`define CRFB_ARCH_REGS   13
`define CRFB_WORD_RST    16'h0000
`define CRFB_LONG_RST    20'h00000
`define CRFB_FLAG_RST    1'b0
`define CRFB_SWI_LAST    6'h1F
`endif

//--- inc/crfb_pkg.sv
// Types of the banked CPU register file
package crfb_pkg;
  typedef enum logic [2:0] {
    CRFB_DATA_ZERO,
    CRFB_DATA_ONE,
    CRFB_DATA_TWO,
    CRFB_DATA_THREE,
    CRFB_ADDR_ZERO,
    CRFB_ADDR_ONE,
    CRFB_FRAME_BASE,
    CRFB_NONE
  } crfb_sel_e;
  typedef enum logic [2:0] {
    CRFB_W_WORD,
    CRFB_W_LOW_BYTE,
    CRFB_W_HIGH_BYTE,
    CRFB_W_DATA_PAIR_LOW,
    CRFB_W_DATA_PAIR_HIGH,
    CRFB_W_ADDR_PAIR
  } crfb_wmode_e;
endpackage

//--- rtl/crfb_bank.sv
// One bank of seven 16-bit general registers
`timescale 1ns/100ps
`include "crfb_defs.svh"
module crfb_bank #(
  parameter int W = `CRFB_WORD_W,
  parameter int N = `CRFB_BANK_REGS
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  // Per-register write
  input  wire logic [N-1:0] we_in,
  input  wire logic [W-1:0] wmask_in,
  input  wire logic [W-1:0] wdata_in [N],
  // Contents
  output logic      [W-1:0] q_out    [N]
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_reg
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          q_out[i] <= `CRFB_WORD_RST;
        end else if (we_in[i]) begin
          q_out[i] <= (q_out[i] & ~wmask_in) | (wdata_in[i] & wmask_in);
        end
      end
    end
  endgenerate
endmodule

//--- rtl/crfb_regfile.sv
// Banked CPU register file with stack pointer and bank selection
`timescale 1ns/100ps
`include "crfb_defs.svh"
module crfb_regfile #(
  parameter int W  = `CRFB_WORD_W,
  parameter int LW = `CRFB_LONG_W,
  parameter int N  = `CRFB_BANK_REGS
) (
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // Banked register write
  input  wire logic                 wr_en_in,
  input  wire crfb_pkg::crfb_sel_e  wr_sel_in,
  input  wire crfb_pkg::crfb_wmode_e wr_mode_in,
  input  wire logic [2*W-1:0]       wr_data_in,
  // Banked register read
  input  wire crfb_pkg::crfb_sel_e  rd_sel_in,
  output logic      [W-1:0]         rd_data_out,
  output logic      [2*W-1:0]       data_pair_low_out,
  output logic      [2*W-1:0]       data_pair_high_out,
  output logic      [2*W-1:0]       addr_pair_out,
  output logic      [W-1:0]         frame_base_out,
  // Program counter and vector table base
  input  wire logic                 pc_we_in,
  input  wire logic [LW-1:0]        pc_data_in,
  input  wire logic                 vtb_we_in,
  input  wire logic [LW-1:0]        vtb_data_in,
  output logic      [LW-1:0]        pc_out,
  output logic      [LW-1:0]        vector_table_base_out,
  // Stack pointers
  input  wire logic                 sp_we_in,
  input  wire logic [W-1:0]         sp_data_in,
  output logic      [W-1:0]         sp_out,
  output logic      [W-1:0]         user_stack_ptr_out,
  output logic      [W-1:0]         irq_stack_ptr_out,
  // Flag bits
  input  wire logic                 flag_we_in,
  input  wire logic                 bank_flag_in,
  input  wire logic                 stack_flag_in,
  input  wire logic                 irq_ack_in,
  input  wire logic                 swi_exec_in,
  input  wire logic [5:0]           swi_num_in,
  output logic                      bank_sel_out,
  output logic                      stack_sel_out
);
  localparam int NREG = `CRFB_ARCH_REGS;
  logic [N-1:0] we0;
  logic [N-1:0] we1;
  logic [N-1:0] we_any;
  logic [W-1:0] wmask;
  logic [W-1:0] wvals [N];
  logic [W-1:0] q0    [N];
  logic [W-1:0] q1    [N];
  logic [W-1:0] cur   [N];
  logic         bank_reg;
  logic         stack_reg;
  logic         stack_clr;
  logic [LW-1:0] pc_reg;
  logic [LW-1:0] vtb_reg;
  logic [W-1:0] usp_reg;
  logic [W-1:0] isp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    we_any = '0;
    wmask  = {W{1'b1}};
    for (int k = 0; k < N; k++) begin
      wvals[k] = wr_data_in[W-1:0];
    end
    case (wr_mode_in)
      crfb_pkg::CRFB_W_LOW_BYTE: begin
        wmask = {{(W/2){1'b0}}, {(W/2){1'b1}}};
        if (wr_sel_in == crfb_pkg::CRFB_DATA_ZERO || wr_sel_in == crfb_pkg::CRFB_DATA_ONE) begin
          we_any[wr_sel_in] = 1'b1;
        end
      end
      crfb_pkg::CRFB_W_HIGH_BYTE: begin
        wmask = {{(W/2){1'b1}}, {(W/2){1'b0}}};
        for (int k = 0; k < N; k++) begin
          wvals[k] = {wr_data_in[W/2-1:0], wr_data_in[W/2-1:0]};
        end
        if (wr_sel_in == crfb_pkg::CRFB_DATA_ZERO || wr_sel_in == crfb_pkg::CRFB_DATA_ONE) begin
          we_any[wr_sel_in] = 1'b1;
        end
      end
      crfb_pkg::CRFB_W_DATA_PAIR_LOW: begin
        we_any[crfb_pkg::CRFB_DATA_ZERO] = 1'b1;
        we_any[crfb_pkg::CRFB_DATA_TWO]  = 1'b1;
        wvals[crfb_pkg::CRFB_DATA_TWO]   = wr_data_in[2*W-1:W];
      end
      crfb_pkg::CRFB_W_DATA_PAIR_HIGH: begin
        we_any[crfb_pkg::CRFB_DATA_ONE]   = 1'b1;
        we_any[crfb_pkg::CRFB_DATA_THREE] = 1'b1;
        wvals[crfb_pkg::CRFB_DATA_THREE]  = wr_data_in[2*W-1:W];
      end
      crfb_pkg::CRFB_W_ADDR_PAIR: begin
        we_any[crfb_pkg::CRFB_ADDR_ZERO] = 1'b1;
        we_any[crfb_pkg::CRFB_ADDR_ONE]  = 1'b1;
        wvals[crfb_pkg::CRFB_ADDR_ONE]   = wr_data_in[2*W-1:W];
      end
      default: begin
        if (wr_sel_in != crfb_pkg::CRFB_NONE) begin
          we_any[wr_sel_in] = 1'b1;
        end
      end
    endcase
    if (!wr_en_in) begin
      we_any = '0;
    end
  end

  assign we0 = bank_reg ? '0 : we_any;
  assign we1 = bank_reg ? we_any : '0;

  ////////////////////////////////////////////////////////////////////////
  // Two banks
  crfb_bank #(.W(W), .N(N)) u_bank0 (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .we_in    (we0),
    .wmask_in (wmask),
    .wdata_in (wvals),
    .q_out    (q0)
  );
  crfb_bank #(.W(W), .N(N)) u_bank1 (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .we_in    (we1),
    .wmask_in (wmask),
    .wdata_in (wvals),
    .q_out    (q1)
  );

  always_comb begin
    for (int k = 0; k < N; k++) begin
      cur[k] = bank_reg ? q1[k] : q0[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read paths
  always_comb begin
    if (rd_sel_in == crfb_pkg::CRFB_NONE) begin
      rd_data_out = '0;
    end else begin
      rd_data_out = cur[rd_sel_in];
    end
  end
  assign data_pair_low_out  = {cur[crfb_pkg::CRFB_DATA_TWO], cur[crfb_pkg::CRFB_DATA_ZERO]};
  assign data_pair_high_out = {cur[crfb_pkg::CRFB_DATA_THREE], cur[crfb_pkg::CRFB_DATA_ONE]};
  assign addr_pair_out      = {cur[crfb_pkg::CRFB_ADDR_ONE], cur[crfb_pkg::CRFB_ADDR_ZERO]};
  assign frame_base_out     = cur[crfb_pkg::CRFB_FRAME_BASE];

  ////////////////////////////////////////////////////////////////////////
  // Flags
  assign stack_clr = irq_ack_in || (swi_exec_in && swi_num_in <= `CRFB_SWI_LAST);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_reg  <= `CRFB_FLAG_RST;
      stack_reg <= `CRFB_FLAG_RST;
    end else begin
      if (flag_we_in) begin
        bank_reg <= bank_flag_in;
      end
      if (stack_clr) begin
        stack_reg <= 1'b0;
      end else if (flag_we_in) begin
        stack_reg <= stack_flag_in;
      end
    end
  end
  assign bank_sel_out  = bank_reg;
  assign stack_sel_out = stack_reg;

  ////////////////////////////////////////////////////////////////////////
  // Program counter and vector table base
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_reg <= `CRFB_LONG_RST;
    end else if (pc_we_in) begin
      pc_reg <= pc_data_in;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vtb_reg <= `CRFB_LONG_RST;
    end else if (vtb_we_in) begin
      vtb_reg <= vtb_data_in;
    end
  end
  assign pc_out                = pc_reg;
  assign vector_table_base_out = vtb_reg;

  ////////////////////////////////////////////////////////////////////////
  // Stack pointers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      usp_reg <= `CRFB_WORD_RST;
      isp_reg <= `CRFB_WORD_RST;
    end else if (sp_we_in) begin
      if (stack_reg) begin
        usp_reg <= sp_data_in;
      end else begin
        isp_reg <= sp_data_in;
      end
    end
  end
  assign sp_out             = stack_reg ? usp_reg : isp_reg;
  assign user_stack_ptr_out = usp_reg;
  assign irq_stack_ptr_out  = isp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_reg_count;
    @(posedge mclk_in) disable iff (!rst_n_in) NREG == N + 6;
  endproperty
  a_reg_count: assert property (p_reg_count) else $error("Register count wrong");
  property p_bank_route;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_en_in && wr_mode_in == crfb_pkg::CRFB_W_WORD && wr_sel_in == crfb_pkg::CRFB_DATA_TWO
       && !flag_we_in) |=> (cur[crfb_pkg::CRFB_DATA_TWO] == $past(wr_data_in[W-1:0]));
  endproperty
  a_bank_route: assert property (p_bank_route) else $error("Word write lost");
  property p_other_bank;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_en_in && !bank_reg) |=> (q1[0] == $past(q1[0]));
  endproperty
  a_other_bank: assert property (p_other_bank) else $error("Idle bank changed");
  property p_low_byte;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_en_in && wr_mode_in == crfb_pkg::CRFB_W_LOW_BYTE && wr_sel_in == crfb_pkg::CRFB_DATA_ZERO
       && !flag_we_in)
      |=> cur[0][W-1:W/2] == $past(cur[0][W-1:W/2]) && cur[0][W/2-1:0] == $past(wr_data_in[W/2-1:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("Byte write wrong");
  property p_pair;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_en_in && wr_mode_in == crfb_pkg::CRFB_W_DATA_PAIR_LOW && !flag_we_in)
      |=> data_pair_low_out == $past(wr_data_in);
  endproperty
  a_pair: assert property (p_pair) else $error("Pair write wrong");
  property p_addr_pair;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_en_in && wr_mode_in == crfb_pkg::CRFB_W_ADDR_PAIR && !flag_we_in)
      |=> addr_pair_out == $past(wr_data_in);
  endproperty
  a_addr_pair: assert property (p_addr_pair) else $error("Address pair wrong");
  property p_sp_sel;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (sp_we_in && !stack_sel_out) |=> irq_stack_ptr_out == $past(sp_data_in);
  endproperty
  a_sp_sel: assert property (p_sp_sel) else $error("Interrupt pointer not written");
  property p_sp_user;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (sp_we_in && stack_sel_out) |=> user_stack_ptr_out == $past(sp_data_in);
  endproperty
  a_sp_user: assert property (p_sp_user) else $error("User pointer not written");
  property p_stack_clr;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (irq_ack_in || (swi_exec_in && swi_num_in < 6'h20)) |=> !stack_sel_out;
  endproperty
  a_stack_clr: assert property (p_stack_clr) else $error("Select not cleared");
  property p_pc;
    @(posedge mclk_in) disable iff (!rst_n_in) pc_we_in |=> pc_out == $past(pc_data_in);
  endproperty
  a_pc: assert property (p_pc) else $error("Counter not loaded");
  property p_vtb;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !vtb_we_in |=> vector_table_base_out == $past(vector_table_base_out);
  endproperty
  a_vtb: assert property (p_vtb) else $error("Table base drifted");
  property p_vtb_load;
    @(posedge mclk_in) disable iff (!rst_n_in)
      vtb_we_in |=> vector_table_base_out == $past(vtb_data_in);
  endproperty
  a_vtb_load: assert property (p_vtb_load) else $error("Table base not loaded");
  c_bank1_write: cover property (@(posedge mclk_in) disable iff (!rst_n_in) wr_en_in && bank_reg);
  c_swi_clear: cover property (@(posedge mclk_in) disable iff (!rst_n_in) swi_exec_in && stack_reg);
  c_high_byte: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    wr_en_in && wr_mode_in == crfb_pkg::CRFB_W_HIGH_BYTE);
endmodule

//--- testbench/cpu_register_file_banked_tb.sv
// Self-checking bench for the banked CPU register file
`timescale 1ns/100ps
module cpu_register_file_banked_tb;
  logic                  mclk;
  logic                  rst_n;
  int                    num_errors = 0;
  int                    n_checks = 0;
  wire logic             wr_en, pc_we, vtb_we, sp_we, flag_we, bf, sf, irq, swi, bsel, ssel;
  crfb_pkg::crfb_sel_e   wr_sel, rd_sel;
  crfb_pkg::crfb_wmode_e wr_mode;
  wire logic [31:0]      wr_data, pl, ph, ap;
  wire logic [19:0]      pc_d, vtb_d, pc, vtb;
  wire logic [15:0]      sp_d, rd, fb, sp, user_stack_ptr, irq_stack_ptr;
  wire logic [5:0]       swi_n;
  crfb_regfile crfb_regfile_inst (.mclk_in(mclk), .rst_n_in(rst_n), .wr_en_in(wr_en),
    .wr_sel_in(wr_sel), .wr_mode_in(wr_mode), .wr_data_in(wr_data), .rd_sel_in(rd_sel),
    .rd_data_out(rd), .data_pair_low_out(pl), .data_pair_high_out(ph), .addr_pair_out(ap),
    .frame_base_out(fb), .pc_we_in(pc_we), .pc_data_in(pc_d), .vtb_we_in(vtb_we),
    .vtb_data_in(vtb_d), .pc_out(pc), .vector_table_base_out(vtb), .sp_we_in(sp_we),
    .sp_data_in(sp_d), .sp_out(sp), .user_stack_ptr_out(user_stack_ptr), .irq_stack_ptr_out(irq_stack_ptr),
    .flag_we_in(flag_we), .bank_flag_in(bf), .stack_flag_in(sf), .irq_ack_in(irq),
    .swi_exec_in(swi), .swi_num_in(swi_n), .bank_sel_out(bsel), .stack_sel_out(ssel));
  crfb_dp_model dp (.mclk_in(mclk), .wr_en_out(wr_en), .wr_sel_out(wr_sel),
    .wr_mode_out(wr_mode), .wr_data_out(wr_data), .rd_sel_out(rd_sel), .pc_we_out(pc_we),
    .pc_data_out(pc_d), .vtb_we_out(vtb_we), .vtb_data_out(vtb_d), .sp_we_out(sp_we),
    .sp_data_out(sp_d), .flag_we_out(flag_we), .bank_flag_out(bf), .stack_flag_out(sf),
    .irq_ack_out(irq), .swi_exec_out(swi), .swi_num_out(swi_n));
  ////////////////////////////////////////////////////////////////////
  // Compare, verdict
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(crfb_pkg::crfb_sel_e s, logic [15:0] exp);
    dp.rd(s);
    #1;
    chk("rd_data", rd, exp);
  endtask
  task automatic results();
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rchk(crfb_pkg::crfb_sel_e'(i), 16'h0000);
    chk("stack_sel", ssel, 32'h0);
    chk("bank_sel", bsel, 32'h0);
  endtask
  task automatic t_bytes();
    dp.wr(crfb_pkg::CRFB_W_WORD, crfb_pkg::CRFB_DATA_ZERO, 32'h0000_1234);
    dp.wr(crfb_pkg::CRFB_W_LOW_BYTE, crfb_pkg::CRFB_DATA_ZERO, 32'h0000_00AB);
    dp.wr(crfb_pkg::CRFB_W_HIGH_BYTE, crfb_pkg::CRFB_DATA_ZERO, 32'h0000_00CD);
    dp.wr(crfb_pkg::CRFB_W_WORD, crfb_pkg::CRFB_DATA_ONE, 32'h0000_5678);
    dp.wr(crfb_pkg::CRFB_W_HIGH_BYTE, crfb_pkg::CRFB_DATA_ONE, 32'h0000_009A);
    dp.wr(crfb_pkg::CRFB_W_LOW_BYTE, crfb_pkg::CRFB_DATA_TWO, 32'h0000_00EE);
    rchk(crfb_pkg::CRFB_DATA_ZERO, 16'hCDAB);
    rchk(crfb_pkg::CRFB_DATA_ONE, 16'h9A78);
    rchk(crfb_pkg::CRFB_DATA_TWO, 16'h0000);
  endtask
  task automatic t_pairs();
    dp.wr(crfb_pkg::CRFB_W_DATA_PAIR_LOW, crfb_pkg::CRFB_NONE, 32'h1111_2222);
    dp.wr(crfb_pkg::CRFB_W_DATA_PAIR_HIGH, crfb_pkg::CRFB_FRAME_BASE, 32'h3333_4444);
    dp.wr(crfb_pkg::CRFB_W_ADDR_PAIR, crfb_pkg::CRFB_DATA_ZERO, 32'h5555_6666);
    dp.wr(crfb_pkg::CRFB_W_WORD, crfb_pkg::CRFB_FRAME_BASE, 32'hFFFF_7777);
    rchk(crfb_pkg::CRFB_ADDR_ONE, 16'h5555);
    chk("pair_low", pl, 32'h1111_2222);
    chk("pair_high", ph, 32'h3333_4444);
    chk("addr_pair", ap, 32'h5555_6666);
    chk("frame_base", fb, 32'h7777);
    rchk(crfb_pkg::CRFB_DATA_TWO, 16'h1111);
  endtask
  task automatic t_banks();
    dp.flags(1'b1, 1'b0);
    dp.wr(crfb_pkg::CRFB_W_WORD, crfb_pkg::CRFB_DATA_ZERO, 32'h0000_BEEF);
    rchk(crfb_pkg::CRFB_DATA_ZERO, 16'hBEEF);
    chk("bank_sel", bsel, 32'h1);
    rchk(crfb_pkg::CRFB_ADDR_ONE, 16'h0000);
    dp.wr(crfb_pkg::CRFB_W_WORD, crfb_pkg::CRFB_DATA_TWO, 32'h0000_CAFE);
    rchk(crfb_pkg::CRFB_DATA_TWO, 16'hCAFE);
    dp.flags(1'b0, 1'b0);
    rchk(crfb_pkg::CRFB_DATA_ZERO, 16'h2222);
    rchk(crfb_pkg::CRFB_DATA_TWO, 16'h1111);
  endtask
  task automatic t_long();
    dp.ld(2'h0, 20'hFFFFF);
    dp.ld(2'h1, 20'hA5A5A);
    rchk(crfb_pkg::CRFB_NONE, 16'h0000);
    chk("pc", pc, 32'hFFFFF);
    chk("vtb", vtb, 32'hA5A5A);
  endtask
  task automatic t_stack();
    dp.ld(2'h2, 20'h00F00);
    dp.flags(1'b0, 1'b1);
    dp.ld(2'h2, 20'h00E00);
    rchk(crfb_pkg::CRFB_NONE, 16'h0000);
    chk("isp", irq_stack_ptr, 32'h0F00);
    chk("usp", user_stack_ptr, 32'h0E00);
    chk("sp", sp, 32'h0E00);
    dp.intr(1'b0, 6'h00);
    rchk(crfb_pkg::CRFB_NONE, 16'h0000);
    chk("stack_sel", ssel, 32'h0);
    chk("sp", sp, 32'h0F00);
    dp.flags(1'b0, 1'b1);
    dp.intr(1'b1, 6'h20);
    rchk(crfb_pkg::CRFB_NONE, 16'h0000);
    chk("stack_sel", ssel, 32'h1);
    dp.intr(1'b1, 6'h1F);
    rchk(crfb_pkg::CRFB_NONE, 16'h0000);
    chk("stack_sel", ssel, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence, watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_bytes();
    t_pairs();
    t_banks();
    t_long();
    t_stack();
    results();
  end
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule

//--- testbench/crfb_dp_model.sv
// Instruction datapath model driving the register file
`timescale 1ns/100ps
module crfb_dp_model (
  // Clock
  input  wire logic            mclk_in,
  // Banked access
  output logic                 wr_en_out,
  output crfb_pkg::crfb_sel_e  wr_sel_out,
  output crfb_pkg::crfb_wmode_e wr_mode_out,
  output logic [31:0]          wr_data_out,
  output crfb_pkg::crfb_sel_e  rd_sel_out,
  // Long registers
  output logic                 pc_we_out,
  output logic [19:0]          pc_data_out,
  output logic                 vtb_we_out,
  output logic [19:0]          vtb_data_out,
  // Stack and flags
  output logic                 sp_we_out,
  output logic [15:0]          sp_data_out,
  output logic                 flag_we_out,
  output logic                 bank_flag_out,
  output logic                 stack_flag_out,
  output logic                 irq_ack_out,
  output logic                 swi_exec_out,
  output logic [5:0]           swi_num_out
);
  ////////////////////////////////////////////////////////////////////
  // Strobes, each set once per falling edge
  task automatic strb(logic [6:0] on);
    {wr_en_out, pc_we_out, vtb_we_out, sp_we_out, flag_we_out, irq_ack_out,
     swi_exec_out} = on;
  endtask
  task automatic rd(crfb_pkg::crfb_sel_e s);
    @(negedge mclk_in);
    strb(7'h00);
    rd_sel_out = s;
  endtask
  task automatic wr(crfb_pkg::crfb_wmode_e m, crfb_pkg::crfb_sel_e s, logic [31:0] d);
    @(negedge mclk_in);
    strb(7'h40);
    wr_mode_out = m;
    wr_sel_out = s;
    wr_data_out = d;
  endtask
  task automatic ld(logic [1:0] k, logic [19:0] d);
    @(negedge mclk_in);
    strb({1'b0, k == 2'h0, k == 2'h1, k == 2'h2, 3'h0});
    pc_data_out = d;
    vtb_data_out = d;
    sp_data_out = d[15:0];
  endtask
  task automatic flags(logic b, logic s);
    @(negedge mclk_in);
    strb(7'h04);
    bank_flag_out = b;
    stack_flag_out = s;
  endtask
  task automatic intr(logic sw, logic [5:0] n);
    @(negedge mclk_in);
    strb({5'h00, ~sw, sw});
    swi_num_out = n;
  endtask
  initial begin
    strb(7'h00);
    wr_sel_out = crfb_pkg::CRFB_NONE;
    rd_sel_out = crfb_pkg::CRFB_NONE;
    wr_mode_out = crfb_pkg::CRFB_W_WORD;
    wr_data_out = 32'h0000_0000;
    pc_data_out = 20'h00000;
    vtb_data_out = 20'h00000;
    sp_data_out = 16'h0000;
    bank_flag_out = 1'b0;
    stack_flag_out = 1'b0;
    swi_num_out = 6'h00;
  end
endmodule
